// ### core/ebc_sequencer.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// - up to five phases in fixed order every cycle; zero-length C, D and F are skipped
// - phase lengths come from timing config
// - setup 1-2 units, plus 0-3 on window change
// - write setup/turnaround phase 0-1 units
// - command delay and hold 0-3 units
// - access phase 1 to 32 units
// - ready may stretch access when enabled
// - read data caught when strobe rises
// - ready polarity selectable
// - async ready adds a sync stage
// - inactive ready waits, active ready ends access
module ebc_sequencer (
  // apb slave
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // external bus
  output logic      [ebc_pkg::EBC_ADDR_W-1:0] bus_addr,
  output logic                               bus_ale,
  output logic                               bus_cs_n,
  output logic                               bus_rd_n,
  output logic                               bus_wr_n,
  output logic      [ebc_pkg::EBC_DATA_W-1:0] bus_data_out,
  output logic                               bus_data_oe_n,
  input  wire logic [ebc_pkg::EBC_DATA_W-1:0] bus_data_in,
  input  wire logic                          bus_ready,
  output logic                               bus_reference_clock_output
);
  import ebc_pkg::*;

  logic [EBC_CFG_W-1:0]  cfg_reg, cfg_next;
  logic [EBC_ADDR_W-1:0] addr_reg, addr_next;
  logic [EBC_DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic                  write_reg, write_next, win_reg, win_next, done_reg, done_next;
  ebc_phase_t            phase_reg, phase_next;
  logic [EBC_CNT_W-1:0]  cnt_reg, cnt_next;
  logic [31:0]           prdata_next;
  logic                  pready_reg, pready_next, pslverr_next;
  logic                  ale_next, cs_next, rd_next, wr_next, oe_next;
  logic                  clk_div_reg;
  logic                  ready_active;

  wire logic apb_access = psel && penable;
  wire logic busy = (phase_reg != EBC_IDLE);

  // registered apb: answer one cycle into the access phase
  function automatic logic known_off(input logic [7:0] a);
    known_off = (a == EBC_CFG_OFF) || (a == EBC_ADDR_OFF) || (a == EBC_WDATA_OFF) ||
                (a == EBC_CTRL_OFF) || (a == EBC_STATUS_OFF) || (a == EBC_RDATA_OFF);
  endfunction

  wire logic wr_take = apb_access && !pready_reg && pwrite;

  // phase lengths in clock units, minus one for counting down
  function automatic logic [EBC_CNT_W-1:0] phase_len(input ebc_phase_t p,
                                                     input logic [EBC_CFG_W-1:0] c,
                                                     input logic w);
    logic [2:0] ab;
    ab = {2'b00, c[EBC_F_AB]};
    if (w)
      ab = ab + {1'b0, c[EBC_F_ABX+:2]};
    case (p)
      EBC_AB:  phase_len = {2'b00, ab};
      EBC_C:   phase_len = {3'b000, c[EBC_F_C+:2]} - 5'd1;
      EBC_D:   phase_len = {4'b0000, c[EBC_F_D]} - 5'd1;
      EBC_E:   phase_len = c[EBC_F_E+:EBC_CNT_W];
      EBC_F:   phase_len = {3'b000, c[EBC_F_F+:2]} - 5'd1;
      default: phase_len = '0;
    endcase
  endfunction

  // phases of zero length are skipped; returns next nonzero phase
  function automatic ebc_phase_t next_ph(input ebc_phase_t p, input logic [EBC_CFG_W-1:0] c);
    case (p)
      EBC_AB:  next_ph = (c[EBC_F_C+:2] != 2'b00) ? EBC_C : (c[EBC_F_D] ? EBC_D : EBC_E);
      EBC_C:   next_ph = c[EBC_F_D] ? EBC_D : EBC_E;
      EBC_D:   next_ph = EBC_E;
      EBC_F:   next_ph = EBC_IDLE;
      default: next_ph = (c[EBC_F_F+:2] != 2'b00) ? EBC_F : EBC_IDLE;
    endcase
  endfunction

  ebc_ready_sync u_rdy (
    .pclk          (pclk),
    .presetn       (presetn),
    .ready_in      (bus_ready),
    .polarity_high (cfg_reg[EBC_F_RDYPOL]),
    .async_mode    (cfg_reg[EBC_F_RDYASY]),
    .ready_active  (ready_active)
  );

  always_comb begin
    cfg_next   = cfg_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    win_next   = win_reg;
    done_next  = done_reg;
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    pready_next = apb_access && !pready_reg;
    pslverr_next = apb_access && !pready_reg && !known_off(paddr);
    prdata_next = '0;
    if (apb_access && !pready_reg && !pwrite) begin
      case (paddr)
        EBC_CFG_OFF:    prdata_next = {15'h0000, cfg_reg};
        EBC_ADDR_OFF:   prdata_next = {8'h00, addr_reg};
        EBC_WDATA_OFF:  prdata_next = {16'h0000, wdata_reg};
        EBC_STATUS_OFF: prdata_next = {30'h00000000, done_reg, busy};
        EBC_RDATA_OFF:  prdata_next = {16'h0000, rdata_reg};
        default:        prdata_next = '0;
      endcase
    end
    // config and buffers only while idle so a cycle in flight stays stable
    if (wr_take && !busy) begin
      case (paddr)
        EBC_CFG_OFF:   cfg_next   = pwdata[EBC_CFG_W-1:0];
        EBC_ADDR_OFF:  addr_next  = pwdata[EBC_ADDR_W-1:0];
        EBC_WDATA_OFF: wdata_next = pwdata[EBC_DATA_W-1:0];
        default: ;
      endcase
    end
    if (wr_take && paddr == EBC_STATUS_OFF && pwdata[EBC_S_DONE])
      done_next = 1'b0;
    case (phase_reg)
      EBC_IDLE: begin
        if (wr_take && paddr == EBC_CTRL_OFF && pwdata[EBC_C_GO]) begin
          write_next = pwdata[EBC_C_WRITE];
          win_next   = pwdata[EBC_C_WIN];
          phase_next = EBC_AB;
          cnt_next   = phase_len(EBC_AB, cfg_reg, pwdata[EBC_C_WIN]);
        end
      end
      EBC_RDY: begin
        if (ready_active) begin
          phase_next = next_ph(EBC_E, cfg_reg);
          cnt_next   = phase_len(EBC_F, cfg_reg, 1'b0);
          if (!write_reg)
            rdata_next = bus_data_in;
        end
      end
      default: begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 5'd1;
        else if (phase_reg == EBC_E && cfg_reg[EBC_F_RDYEN])
          phase_next = EBC_RDY;
        else begin
          phase_next = next_ph(phase_reg, cfg_reg);
          cnt_next   = phase_len(next_ph(phase_reg, cfg_reg), cfg_reg, 1'b0);
          if (phase_reg == EBC_E && !write_reg)
            rdata_next = bus_data_in;
        end
      end
    endcase
    // after the clear, so a finishing cycle beats a done clear
    if (phase_next == EBC_IDLE && phase_reg != EBC_IDLE)
      done_next = 1'b1;
    if (phase_reg == EBC_IDLE && phase_next == EBC_AB)
      cnt_next = phase_len(EBC_AB, cfg_reg, win_next) - 5'd0;
    // strobes as seen in the next cycle
    ale_next = (phase_next == EBC_AB);
    cs_next  = !(phase_next != EBC_IDLE);
    rd_next  = !((phase_next == EBC_D || phase_next == EBC_E || phase_next == EBC_RDY) && !write_next);
    wr_next  = !((phase_next == EBC_E || phase_next == EBC_RDY) && write_next);
    // mux mode leaves C as turnaround; demultiplexed_bus_mode drives write data from C on
    oe_next  = !(write_next && phase_next != EBC_IDLE && phase_next != EBC_AB &&
                 !(cfg_reg[EBC_F_MUX] && phase_next == EBC_C)) &&
               !(cfg_reg[EBC_F_MUX] && phase_next == EBC_AB);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg    <= EBC_CFG_RST;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      write_reg  <= 1'b0;
      win_reg    <= 1'b0;
      done_reg   <= 1'b0;
      phase_reg  <= EBC_IDLE;
      cnt_reg    <= '0;
      pready_reg <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= '0;
      bus_ale    <= 1'b0;
      bus_cs_n   <= 1'b1;
      bus_rd_n   <= 1'b1;
      bus_wr_n   <= 1'b1;
      bus_data_oe_n <= 1'b1;
      bus_addr   <= '0;
      bus_data_out <= '0;
      clk_div_reg <= 1'b0;
    end else begin
      cfg_reg    <= cfg_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      write_reg  <= write_next;
      win_reg    <= win_next;
      done_reg   <= done_next;
      phase_reg  <= phase_next;
      cnt_reg    <= cnt_next;
      pready_reg <= pready_next;
      pslverr    <= pslverr_next;
      prdata     <= prdata_next;
      bus_ale    <= ale_next;
      bus_cs_n   <= cs_next;
      bus_rd_n   <= rd_next;
      bus_wr_n   <= wr_next;
      bus_data_oe_n <= oe_next;
      bus_addr   <= addr_next;
      bus_data_out <= (cfg_reg[EBC_F_MUX] && phase_next == EBC_AB) ? addr_next[EBC_DATA_W-1:0] : wdata_next;
      clk_div_reg <= !clk_div_reg;
    end
  end

  always_comb begin
    pready = pready_reg;
    bus_reference_clock_output = clk_div_reg;
  end
endmodule // ebc_sequencer

// ### core/ebc_pkg.sv
package ebc_pkg;
  // apb register map (byte addresses)
  localparam logic [7:0] EBC_CFG_OFF     = 8'h00;
  localparam logic [7:0] EBC_ADDR_OFF    = 8'h04;
  localparam logic [7:0] EBC_WDATA_OFF   = 8'h08;
  localparam logic [7:0] EBC_CTRL_OFF    = 8'h0c;
  localparam logic [7:0] EBC_STATUS_OFF  = 8'h10;
  localparam logic [7:0] EBC_RDATA_OFF   = 8'h14;
  // chip_select_timing_config field positions
  localparam int EBC_F_AB    = 0;   // 1 bit: setup 1 or 2 units
  localparam int EBC_F_ABX   = 1;   // 2 bits: extension on window change
  localparam int EBC_F_C     = 3;   // 2 bits
  localparam int EBC_F_D     = 5;   // 1 bit
  localparam int EBC_F_E     = 6;   // 5 bits: access length minus one
  localparam int EBC_F_F     = 11;  // 2 bits
  localparam int EBC_F_RDYEN = 13;
  localparam int EBC_F_RDYPOL = 14; // 1: ready active high
  localparam int EBC_F_RDYASY = 15;
  localparam int EBC_F_MUX   = 16;
  localparam int EBC_CFG_W   = 17;
  localparam logic [EBC_CFG_W-1:0] EBC_CFG_RST = 17'h00040;
  // ctrl bits
  localparam int EBC_C_GO    = 0;
  localparam int EBC_C_WRITE = 1;
  localparam int EBC_C_WIN   = 2;   // address window changed
  // status bits
  localparam int EBC_S_BUSY  = 0;
  localparam int EBC_S_DONE  = 1;
  localparam int EBC_ADDR_W  = 24;
  localparam int EBC_DATA_W  = 16;
  localparam int EBC_CNT_W   = 5;
  typedef enum logic [2:0] {
    EBC_IDLE, EBC_AB, EBC_C, EBC_D, EBC_E, EBC_RDY, EBC_F
  } ebc_phase_t;
endpackage

// ### core/ebc_ready_sync.sv
`timescale 1ns/1ps
module ebc_ready_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // ready path
  input  wire logic ready_in,
  input  wire logic polarity_high,
  input  wire logic async_mode,
  output logic      ready_active
);
  logic s1_reg, s2_reg;
  logic s1_next, s2_next;

  always_comb begin
    s1_next = ready_in;
    s2_next = s1_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  // async takes the synchronised level, sync takes the pin directly
  always_comb begin
    ready_active = (async_mode ? s2_reg : ready_in) == polarity_high;
  end
endmodule // ebc_ready_sync

// ### bench/ebc_sequencer_monitor.sv
`timescale 1ns/1ps
module ebc_sequencer_monitor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // external bus
  input wire logic bus_ale,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic bus_data_oe_n,
  input wire logic bus_reference_clock_output
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_STROBES_EXCL: assert property (bus_rd_n || bus_wr_n)
    else $error("both strobes low");
  AST_STROBE_IN_CS: assert property (!(bus_rd_n && bus_wr_n) |-> !bus_cs_n)
    else $error("strobe outside chip select");
  AST_CYCLE_OPENS_SETUP: assert property ($fell(bus_cs_n) |-> bus_ale)
    else $error("cycle did not open with setup");
  AST_SETUP_NO_STROBE: assert property (bus_ale |-> bus_rd_n && bus_wr_n && !bus_cs_n)
    else $error("strobe during setup");
  AST_READ_RELEASED: assert property (!bus_rd_n |-> bus_data_oe_n)
    else $error("data driven during read");
  AST_WRITE_DRIVEN: assert property (!bus_wr_n |-> !bus_data_oe_n)
    else $error("write data not driven");
  AST_REF_CLK: assert property (1'b1 |=> bus_reference_clock_output != $past(bus_reference_clock_output))
    else $error("reference clock stuck");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  cover property (!bus_rd_n ##1 bus_rd_n);
  cover property (!bus_wr_n ##1 bus_wr_n);
  cover property (pslverr);
endmodule // ebc_sequencer_monitor
bind ebc_sequencer ebc_sequencer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .bus_ale(bus_ale), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
  .bus_wr_n(bus_wr_n), .bus_data_oe_n(bus_data_oe_n), .bus_reference_clock_output(bus_reference_clock_output));

// ### bench/ebc_ext_mem.sv
`timescale 1ns/1ps
module ebc_ext_mem (
  // bus side
  input  wire logic        pclk,
  input  wire logic [23:0] bus_addr,
  input  wire logic        bus_rd_n,
  input  wire logic        bus_wr_n,
  input  wire logic [15:0] bus_data_out,
  output logic      [15:0] bus_data_in,
  output logic             bus_ready,
  // behaviour
  input  wire logic        rdy_high,
  input  wire logic [3:0]  rdy_wait
);
  logic [15:0] mem [16];
  logic [3:0]  a = 4'h0;
  logic [3:0]  cnt = 4'h0;
  always @(posedge pclk) begin
    if (!bus_wr_n)
      mem[bus_addr[3:0]] <= bus_data_out;
    cnt <= (bus_rd_n && bus_wr_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
  end
  always @(negedge bus_rd_n) a = bus_addr[3:0];
  // released bus shows the inverse of the last word
  assign bus_data_in = bus_rd_n ? ~mem[a] : mem[a];
  assign bus_ready = (!(bus_rd_n && bus_wr_n) && cnt >= rdy_wait) ? rdy_high : !rdy_high;
endmodule // ebc_ext_mem

// ### bench/ebc_sequencer_tb_top.sv
`timescale 1ns/1ps
module ebc_sequencer_tb_top;
  import ebc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rdy_high = 1, er;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, bus_ale, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe_n, bus_ready, ref_clk;
  logic [23:0] bus_addr;
  logic [15:0] bus_data_out, bus_data_in;
  logic [3:0]  rdy_wait = 4'h5;
  int          error_cnt = 0, comparisons = 0, n_ale, n_str, n_cs;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    n_ale += bus_ale;
    n_str += !(bus_rd_n && bus_wr_n);
    n_cs += !bus_cs_n;
  end
  ebc_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_addr(bus_addr),
    .bus_ale(bus_ale), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .bus_data_in(bus_data_in), .bus_ready(bus_ready),
    .bus_reference_clock_output(ref_clk));
  ebc_ext_mem u_mem (.pclk(pclk), .bus_addr(bus_addr), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_data_out(bus_data_out), .bus_data_in(bus_data_in), .bus_ready(bus_ready), .rdy_high(rdy_high),
    .rdy_wait(rdy_wait));
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bound(input logic ok);
    if (!ok) begin
      error_cnt++;
      $display("ERROR %0t: wait timed out", $time);
      wrap_up();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bound(n < 50);
  endtask
  function automatic logic [16:0] mk(int ab, ext, c, dd, e, f, ren, pol, asy, multiplexed_bus_mode);
    return 17'((ab << EBC_F_AB) | (ext << EBC_F_ABX) | (c << EBC_F_C) | (dd << EBC_F_D) | (e << EBC_F_E)
      | (f << EBC_F_F) | (ren << EBC_F_RDYEN) | (pol << EBC_F_RDYPOL) | (asy << EBC_F_RDYASY) | (multiplexed_bus_mode << EBC_F_MUX));
  endfunction
  // one bus cycle, then read back rdata
  task automatic bus_op(input logic [16:0] cfg, input logic wr, input logic win, input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, EBC_CFG_OFF, {15'h0, cfg});
    apb(1'b1, EBC_ADDR_OFF, 32'h5);
    apb(1'b1, EBC_WDATA_OFF, {16'h0, d});
    n_ale = 0;
    n_str = 0;
    n_cs = 0;
    apb(1'b1, EBC_CTRL_OFF, {29'h0, win, wr, 1'b1});
    do begin
      apb(1'b0, EBC_STATUS_OFF, 32'h0);
      n++;
    end while (rd[EBC_S_DONE] !== 1'b1 && n < 100);
    bound(n < 100);
    apb(1'b1, EBC_STATUS_OFF, 32'h2);
    apb(1'b0, EBC_RDATA_OFF, 32'h0);
  endtask
  task automatic t_regs;
    apb(1'b0, EBC_CFG_OFF, 32'h0);
    chk(rd, {15'h0, EBC_CFG_RST}, "cfg reset");
    apb(1'b0, EBC_STATUS_OFF, 32'h0);
    chk(rd, 32'h0, "status reset");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    $display("test regs done");
  endtask
  task automatic t_write_long;
    bus_op(mk(1, 3, 3, 1, 31, 3, 0, 1, 0, 0), 1'b1, 1'b1, 16'ha5c3);
    chk(n_ale, 32'h5, "setup length");
    chk(n_str, 32'h20, "access length");
    chk(n_cs, 32'h2c, "cycle length");
    $display("test write_long done");
  endtask
  task automatic t_read_short;
    bus_op(mk(0, 3, 0, 1, 0, 0, 0, 1, 0, 1), 1'b0, 1'b0, 16'h0);
    chk(rd, 32'ha5c3, "read data");
    chk(n_ale, 32'h1, "setup without window");
    chk(n_str, 32'h2, "turnaround plus access");
    chk(n_cs, 32'h3, "short cycle");
    $display("test read_short done");
  endtask
  task automatic t_ready;
    int prev;
    prev = 0;
    for (int pol = 0; pol < 2; pol++) begin
      for (int asy = 0; asy < 2; asy++) begin
        rdy_high <= 1'(pol);
        bus_op(mk(0, 0, 0, 0, 0, 0, 1, pol, asy, 0), 1'b0, 1'b0, 16'h0);
        chk(rd, 32'ha5c3, "read data after waits");
        chk({31'h0, n_str >= 6}, 32'h1, "strobe held for ready");
        if (asy == 1)
          chk({31'h0, n_str > prev}, 32'h1, "sync stage wait");
        prev = n_str;
      end
    end
    $display("test ready done");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write_long();
    t_read_short();
    t_ready();
    wrap_up();
  end
endmodule // ebc_sequencer_tb_top
